// File: instruction_exec_subset.sv
// Execution unit for clear, call, watchdog kick, complement and decrement.
// Assumes the register file answers fileRdData combinationally for the address field of fetchedInsn
// and that the stack, watchdog and prescaler act on one-cycle strobes.
`timescale 1ns/1ps
module instruction_exec_subset
   import exec_subset_pkg::*;
(
   input wire logic core_clk, // Instruction clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [INSN_W-1:0] fetchedInsn, // Prefetched instruction word
   input wire logic [DATA_W-1:0] fileRdData, // Addressed register contents
   input wire logic [DATA_W-1:0] statusIn, // Current status register
   input wire logic prescalerToWdog, // Prescaler serves the watchdog
   output logic [PC_W-1:0] programCounter, // Program counter
   output logic [DATA_W-1:0] accumulator, // Working accumulator
   output logic [FADDR_W-1:0] fileAddr, // Register file address
   output logic [DATA_W-1:0] fileWrData, // Register file write data
   output logic fileWrEn, // Register file write strobe
   output logic stackPush, // Return stack push strobe
   output logic [PC_W-1:0] stackData, // Return address to push
   output logic wdogClear, // Watchdog counter clear strobe
   output logic prescalerClear, // Prescaler clear strobe
   output logic nullResultFlag, // Null result flag
   output logic timeoutFlag_n, // Timeout flag, active low
   output logic sleepEnteredFlag_n, // Sleep flag, active low
   output logic flushing // Second cycle of a two-cycle instruction
);
   ////////////////////////////////////////////////////////////////////////
   logic isClrAcc, isCall, isKick, isClrF, isComF, isDecF, isDecSz;
   logic [INSN_W-1:0] insn;
   exec_state_type state, next_state;
   logic [PC_W-1:0] next_programCounter, next_stackData;
   logic [DATA_W-1:0] next_accumulator, next_fileWrData, result;
   logic [FADDR_W-1:0] next_fileAddr;
   logic next_fileWrEn, next_stackPush, next_wdogClear, next_prescalerClear;
   logic next_nullResultFlag, next_timeoutFlag_n, next_sleepEnteredFlag_n;
   logic next_flushing, toFile, hasResult;

   ////////////////////////////////////////////////////////////////////////
   // Zero test and decrement serve several opcodes, so each is written once.
   function automatic logic is_zero(input logic [DATA_W-1:0] value);
      return (value == ZERO_BYTE);
   endfunction

   // The subtraction wraps at the byte boundary; no borrow leaves the block.
   function automatic logic [DATA_W-1:0] dec_byte(input logic [DATA_W-1:0] value);
      return value - ONE_BYTE;
   endfunction

   // A flushed slot runs as a no-operation rather than the prefetched word.
   assign insn = (state == EXEC_FLUSH) ? NOP_WORD : fetchedInsn;

   exec_decode u_decode (
      .insn(insn),
      .isClrAcc(isClrAcc),
      .isCall(isCall),
      .isKick(isKick),
      .isClrF(isClrF),
      .isComF(isComF),
      .isDecF(isDecF),
      .isDecSz(isDecSz)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = EXEC_RUN;
      next_programCounter = programCounter + PC_ONE;
      next_accumulator = accumulator;
      next_fileAddr = insn[FADDR_W-1:0];
      next_fileWrData = fileWrData;
      next_fileWrEn = 1'b0;
      next_stackPush = 1'b0;
      next_stackData = stackData;
      next_wdogClear = 1'b0;
      next_prescalerClear = 1'b0;
      next_nullResultFlag = nullResultFlag;
      next_timeoutFlag_n = timeoutFlag_n;
      next_sleepEnteredFlag_n = sleepEnteredFlag_n;
      next_flushing = 1'b0;
      toFile = insn[DEST_BIT];
      hasResult = 1'b0;
      result = ZERO_BYTE;
      if (isClrAcc)
      begin
         next_accumulator = ZERO_BYTE;
         next_nullResultFlag = 1'b1;
      end
      else if (isCall)
      begin
         next_stackPush = 1'b1;
         next_stackData = programCounter + PC_ONE;
         next_programCounter = {statusIn[PAGE_HI:PAGE_LO], 1'b0,
                                insn[DATA_W-1:0]};
         next_state = EXEC_FLUSH;
         next_flushing = 1'b1;
      end
      else if (isKick)
      begin
         next_wdogClear = 1'b1;
         next_prescalerClear = prescalerToWdog;
         next_timeoutFlag_n = 1'b1;
         next_sleepEnteredFlag_n = 1'b1;
      end
      else if (isClrF)
      begin
         hasResult = 1'b1;
         // Clearing always writes the register, whatever the destination bit holds.
         toFile = 1'b1;
         result = ZERO_BYTE;
         next_nullResultFlag = 1'b1;
      end
      else if (isComF)
      begin
         hasResult = 1'b1;
         result = ~fileRdData;
         next_nullResultFlag = is_zero(result);
      end
      else if (isDecF)
      begin
         hasResult = 1'b1;
         result = dec_byte(fileRdData);
         next_nullResultFlag = is_zero(result);
      end
      else if (isDecSz)
      begin
         // Flags deliberately stay as they are here.
         hasResult = 1'b1;
         result = dec_byte(fileRdData);
         if (is_zero(result))
         begin
            next_state = EXEC_FLUSH;
            next_flushing = 1'b1;
         end
      end
      if (hasResult)
      begin
         if (toFile)
         begin
            next_fileWrEn = 1'b1;
            next_fileWrData = result;
         end
         else
         begin
            next_accumulator = result;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= EXEC_RUN;
         programCounter <= PC_RESET;
         accumulator <= ZERO_BYTE;
         fileAddr <= '0;
         fileWrData <= ZERO_BYTE;
         fileWrEn <= 1'b0;
         stackPush <= 1'b0;
         stackData <= PC_RESET;
         wdogClear <= 1'b0;
         prescalerClear <= 1'b0;
         nullResultFlag <= 1'b0;
         timeoutFlag_n <= 1'b1;
         sleepEnteredFlag_n <= 1'b1;
         flushing <= 1'b0;
      end
      else
      begin
         state <= next_state;
         programCounter <= next_programCounter;
         accumulator <= next_accumulator;
         fileAddr <= next_fileAddr;
         fileWrData <= next_fileWrData;
         fileWrEn <= next_fileWrEn;
         stackPush <= next_stackPush;
         stackData <= next_stackData;
         wdogClear <= next_wdogClear;
         prescalerClear <= next_prescalerClear;
         nullResultFlag <= next_nullResultFlag;
         timeoutFlag_n <= next_timeoutFlag_n;
         sleepEnteredFlag_n <= next_sleepEnteredFlag_n;
         flushing <= next_flushing;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Each antecedent that decodes the instruction also needs the sampled reset high: the edge that releases
   // reset still finds the registers held, so nothing is executed there.
   a_clracc_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isClrAcc |=> accumulator == ZERO_BYTE && nullResultFlag)
      else $error("clear accumulator failed");
   a_clracc_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isClrAcc |=> !fileWrEn && !stackPush && !flushing)
      else $error("clear accumulator touched other state");
   a_call_push: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isCall |=> stackPush && stackData == $past(programCounter) + PC_ONE)
      else $error("call push wrong");
   a_push_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      stackPush |=> !stackPush)
      else $error("push strobe longer than one cycle");
   a_call_target: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isCall |=> programCounter[DATA_W-1:0] == $past(insn[DATA_W-1:0]))
      else $error("call target low bits wrong");
   a_call_page: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isCall |=> !programCounter[PC_CLR_BIT]
         && programCounter[PC_W-1:PC_W-2] == $past(statusIn[PAGE_HI:PAGE_LO]))
      else $error("call page bits wrong");
   a_call_twocycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isCall |=> flushing && $stable(nullResultFlag) ##1 !flushing)
      else $error("call not two cycles");
   a_call_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isCall |=> !fileWrEn && $stable(accumulator) && $stable(timeoutFlag_n)
         && $stable(sleepEnteredFlag_n))
      else $error("call changed data or flags");

   ////////////////////////////////////////////////////////////////////////
   // A discarded slot may only step the counter; anything else is a leak.
   a_flush_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      flushing |=> !fileWrEn && !stackPush && !wdogClear && !flushing
         && $stable(accumulator) && $stable(nullResultFlag))
      else $error("discarded slot had an effect");
   a_kick_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isKick |=> wdogClear && prescalerClear == $past(prescalerToWdog))
      else $error("kick clear wrong");
   a_kick_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isKick && !prescalerToWdog |=> !prescalerClear)
      else $error("prescaler cleared while serving the timer");
   a_wdog_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && !isKick |=> !wdogClear && !prescalerClear)
      else $error("watchdog cleared without a kick");
   a_kick_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isKick |=> timeoutFlag_n && sleepEnteredFlag_n)
      else $error("kick flags not set");
   a_kick_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isKick |=> !fileWrEn && !flushing && $stable(accumulator)
         && $stable(nullResultFlag))
      else $error("kick touched data or null flag");

   ////////////////////////////////////////////////////////////////////////
   a_clear_file_reg_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isClrF |=> fileWrEn && fileWrData == ZERO_BYTE && nullResultFlag)
      else $error("clear register failed");
   a_clear_file_reg_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isClrF |=> fileAddr == $past(insn[FADDR_W-1:0]) && $stable(accumulator))
      else $error("clear register address or accumulator wrong");
   a_addr_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && (isComF || isDecF || isDecSz) |=> fileAddr == $past(insn[FADDR_W-1:0]))
      else $error("register address does not follow instruction");
   a_invert_file_reg_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isComF && !insn[DEST_BIT] |=> !fileWrEn && accumulator == ~$past(fileRdData)
         && nullResultFlag == ($past(fileRdData) == ~ZERO_BYTE))
      else $error("complement wrong");
   a_invert_file_reg_file: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isComF && insn[DEST_BIT] |=> fileWrEn && fileWrData == ~$past(fileRdData)
         && $stable(accumulator) && nullResultFlag == ($past(fileRdData) == ~ZERO_BYTE))
      else $error("complement to register wrong");
   a_decrement_file_reg_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecF && insn[DEST_BIT] |=> fileWrEn
         && fileWrData == $past(fileRdData) - ONE_BYTE
         && nullResultFlag == ($past(fileRdData) == ONE_BYTE))
      else $error("decrement wrong");
   a_decrement_file_reg_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecF && !insn[DEST_BIT] |=> !fileWrEn
         && accumulator == $past(fileRdData) - ONE_BYTE
         && nullResultFlag == ($past(fileRdData) == ONE_BYTE))
      else $error("decrement to accumulator wrong");
   a_decsz_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecSz |=> $stable(nullResultFlag) && $stable(timeoutFlag_n)
         && $stable(sleepEnteredFlag_n))
      else $error("skip decrement touched flags");
   a_decsz_dest: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecSz && !insn[DEST_BIT] |=> !fileWrEn
         && accumulator == $past(fileRdData) - ONE_BYTE)
      else $error("skip decrement to accumulator wrong");
   a_decsz_file: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecSz && insn[DEST_BIT] |=> fileWrEn
         && fileWrData == $past(fileRdData) - ONE_BYTE)
      else $error("skip decrement to register wrong");
   a_decsz_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && isDecSz && fileRdData == ONE_BYTE |=> flushing ##1 !flushing)
      else $error("skip not taken");
   a_single_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && (isClrF || isComF || isDecF || (isDecSz && fileRdData != ONE_BYTE))
      |=> !flushing)
      else $error("single cycle instruction stalled");
   a_pc_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && !isCall |=> programCounter == $past(programCounter) + PC_ONE)
      else $error("program counter did not advance");
   a_unknown_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n && !(isClrAcc || isCall || isKick || isClrF || isComF || isDecF || isDecSz)
      |=> !fileWrEn && !stackPush && !wdogClear && !flushing
         && $stable(accumulator) && $stable(nullResultFlag))
      else $error("unknown opcode had an effect");
endmodule // instruction_exec_subset

// File: exec_subset_pkg.sv
// Shared constants for the instruction execution subset.
// Assumes a 12-bit instruction word and an 8-bit data path.
package exec_subset_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int INSN_W = 12;
   localparam int FADDR_W = 5;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [PC_W-1:0] PC_ONE = 11'h001;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [INSN_W-1:0] NOP_WORD = 12'h000;
   // Opcode patterns of the decoded subset.
   localparam logic [INSN_W-1:0] OP_CLRACC = 12'h040;
   localparam logic [INSN_W-1:0] OP_KICKWD = 12'h004;
   localparam logic [3:0] OP_CALL_HI = 4'h9;
   localparam logic [6:0] OP_CLEAR_FILE_REG_HI = 7'h03;
   localparam logic [5:0] OP_INVERT_FILE_REG_HI = 6'h09;
   localparam logic [5:0] OP_DECREMENT_FILE_REG_HI = 6'h03;
   localparam logic [5:0] OP_DECSZ_HI = 6'h0B;
   // Field positions.
   localparam int DEST_BIT = 5;
   localparam int PAGE_LO = 5;
   localparam int PAGE_HI = 6;
   localparam int PC_CLR_BIT = 8;
   // Bit positions of status flags inside the returned status vector.
   localparam int ZFLAG_BIT = 2;
   localparam int PDFLAG_BIT = 3;
   localparam int TOFLAG_BIT = 4;
   typedef enum logic [1:0] {
      EXEC_RUN = 2'b00,
      EXEC_FLUSH = 2'b01
   } exec_state_type;
endpackage

// File: exec_decode.sv
// Combinational decoder for the instruction subset.
// Assumes the instruction word is stable for the whole instruction cycle.
`timescale 1ns/1ps
module exec_decode
   import exec_subset_pkg::*;
(
   input wire logic [INSN_W-1:0] insn, // Instruction word being executed
   output logic isClrAcc, // Clear accumulator
   output logic isCall, // Subroutine jump
   output logic isKick, // Watchdog kick
   output logic isClrF, // Clear file register
   output logic isComF, // Complement file register
   output logic isDecF, // Decrement file register
   output logic isDecSz // Decrement, skip if zero
);
   always_comb
   begin
      isClrAcc = (insn == OP_CLRACC);
      isKick = (insn == OP_KICKWD);
      isCall = (insn[INSN_W-1 -: $bits(OP_CALL_HI)] == OP_CALL_HI);
      isClrF = (insn[INSN_W-1 -: $bits(OP_CLEAR_FILE_REG_HI)] == OP_CLEAR_FILE_REG_HI);
      isComF = (insn[INSN_W-1 -: $bits(OP_INVERT_FILE_REG_HI)] == OP_INVERT_FILE_REG_HI);
      isDecF = (insn[INSN_W-1 -: $bits(OP_DECREMENT_FILE_REG_HI)] == OP_DECREMENT_FILE_REG_HI);
      isDecSz = (insn[INSN_W-1 -: $bits(OP_DECSZ_HI)] == OP_DECSZ_HI);
   end
endmodule // exec_decode

// File: tb.sv
// Self-checking bench for the instruction execution subset.
// Assumes a 50 MHz core clock; the bench stands in for register file, status and stack.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
      end \
   end
module tb
   import exec_subset_pkg::*;
();
   typedef struct packed {
      logic [INSN_W-1:0] insn;
      logic [DATA_W-1:0] rd;
      logic [DATA_W-1:0] res;
      logic toFile;
      logic zUpd;
   } row_type;
   logic core_clk = 1'b0, rst_n = 1'b0, prescalerToWdog = 1'b1;
   logic [INSN_W-1:0] fetchedInsn = NOP_WORD;
   logic [DATA_W-1:0] fileRdData = ZERO_BYTE, statusIn = ZERO_BYTE;
   logic [PC_W-1:0] programCounter, stackData;
   logic [DATA_W-1:0] accumulator, fileWrData;
   logic [FADDR_W-1:0] fileAddr;
   logic fileWrEn, stackPush, wdogClear, prescalerClear, nullResultFlag;
   logic timeoutFlag_n, sleepEnteredFlag_n, flushing;
   logic expZ = 1'b0;
   logic [DATA_W-1:0] expAcc = ZERO_BYTE;
   int failures = 0, comparisons = 0;
   // Ordinary cases; each row after the first is chosen so the null flag toggles or must hold.
   row_type rows [0:8] = '{
      '{12'h242, 8'h0F, 8'hF0, 1'b0, 1'b1}, '{12'h07F, 8'hAA, 8'h00, 1'b1, 1'b1},
      '{12'h0C1, 8'h00, 8'hFF, 1'b0, 1'b1}, '{12'h2E9, 8'h80, 8'h7F, 1'b1, 1'b0},
      '{12'h0FF, 8'h01, 8'h00, 1'b1, 1'b1}, '{12'h2C7, 8'h02, 8'h01, 1'b0, 1'b0},
      '{12'h265, 8'h00, 8'hFF, 1'b1, 1'b1}, '{12'h040, 8'h55, 8'h00, 1'b0, 1'b1},
      '{12'h242, 8'h0F, 8'hF0, 1'b0, 1'b1}};

   instruction_exec_subset instruction_exec_subset_inst (.core_clk(core_clk), .rst_n(rst_n),
      .fetchedInsn(fetchedInsn), .fileRdData(fileRdData), .statusIn(statusIn),
      .prescalerToWdog(prescalerToWdog), .programCounter(programCounter),
      .accumulator(accumulator), .fileAddr(fileAddr), .fileWrData(fileWrData),
      .fileWrEn(fileWrEn), .stackPush(stackPush), .stackData(stackData),
      .wdogClear(wdogClear), .prescalerClear(prescalerClear),
      .nullResultFlag(nullResultFlag), .timeoutFlag_n(timeoutFlag_n),
      .sleepEnteredFlag_n(sleepEnteredFlag_n), .flushing(flushing));

   initial
   begin
      forever #10 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs change by non-blocking assignment at the edge, so the instruction
   // driven here is taken at the next edge and checked just after it.
   task automatic apply(input logic [INSN_W-1:0] i, input logic [DATA_W-1:0] r,
      input logic p);
      @(posedge core_clk);
      fetchedInsn <= i;
      fileRdData <= r;
      prescalerToWdog <= p;
      #1;
   endtask

   task automatic check_row(input row_type r);
      expZ = r.zUpd ? (r.res == ZERO_BYTE) : expZ;
      expAcc = r.toFile ? expAcc : r.res;
      `CHK(fileWrEn, r.toFile)
      if (r.toFile)
      begin
         `CHK(fileWrData, r.res)
         `CHK(fileAddr, r.insn[4:0])
      end
      `CHK(accumulator, expAcc)
      `CHK(nullResultFlag, expZ)
      `CHK(flushing, 1'b0)
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      // About 23 cycles are needed; the limit leaves ample margin.
      #20000;
      failures++;
      finish_test();
   end

   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 9; k++)
      begin
         apply(rows[k].insn, rows[k].rd, 1'b1);
         if (k > 0)
            check_row(rows[k-1]);
      end
      apply(OP_KICKWD, ZERO_BYTE, 1'b1);
      check_row(rows[8]);
      apply(OP_KICKWD, ZERO_BYTE, 1'b0);
      `CHK(wdogClear, 1'b1)
      `CHK(prescalerClear, 1'b1)
      `CHK({timeoutFlag_n, sleepEnteredFlag_n}, 2'b11)
      `CHK(accumulator, 8'hF0)
      apply(12'h2E3, 8'h01, 1'b0);
      `CHK(wdogClear, 1'b1)
      `CHK(prescalerClear, 1'b0)
      // The word offered during the discard cycle would load FF into the accumulator.
      apply(12'h240, 8'h00, 1'b0);
      `CHK({fileWrEn, fileAddr, fileWrData}, {1'b1, 5'h03, 8'h00})
      `CHK(nullResultFlag, 1'b0)
      `CHK(flushing, 1'b1)
      apply(NOP_WORD, ZERO_BYTE, 1'b0);
      `CHK({flushing, fileWrEn, accumulator}, {1'b0, 1'b0, 8'hF0})
      // Second reset in mid-run, then a call taken at program counter zero.
      @(posedge core_clk);
      rst_n <= 1'b0;
      fetchedInsn <= 12'h9FF;
      statusIn <= 8'hBF;
      #1;
      `CHK({programCounter, accumulator, nullResultFlag}, {PC_RESET, ZERO_BYTE, 1'b0})
      `CHK({stackPush, fileWrEn, flushing}, 3'b000)
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      apply(12'h0C0, 8'h00, 1'b0);
      `CHK({stackPush, stackData}, {1'b1, PC_ONE})
      `CHK(programCounter, 11'h2FF)
      `CHK(flushing, 1'b1)
      `CHK(nullResultFlag, 1'b0)
      apply(NOP_WORD, ZERO_BYTE, 1'b0);
      `CHK({programCounter, flushing, stackPush}, {11'h300, 2'b00})
      `CHK({accumulator, nullResultFlag}, {ZERO_BYTE, 1'b0})
      finish_test();
   end
endmodule // tb
